/* verilog/dio_pkg.sv */
/*
 * Constants, types and helpers shared by the digital I/O object block.
 * Assumes one control clock and an object access port driven by the fieldbus side.
 */
`default_nettype none

package dio_pkg;

    // object indices and subindices
    localparam logic [15:0] DIO_IDX_ENCODER = 16'h60E4;
    localparam logic [15:0] DIO_IDX_INPUTS = 16'h60FD;
    localparam logic [15:0] DIO_IDX_OUTPUTS = 16'h60FE;
    localparam logic [7:0] DIO_SUB_COUNT = 8'h00;
    localparam logic [7:0] DIO_SUB_ENC_POS = 8'h01;
    localparam logic [7:0] DIO_SUB_OUT_WORD = 8'h01;
    localparam logic [7:0] DIO_SUB_MASK = 8'h02;

    // fixed entry counts
    localparam logic [7:0] DIO_ENC_COUNT = 8'h01;
    localparam logic [7:0] DIO_OUT_COUNT = 8'h02;

    // input word field positions
    localparam int DIO_BIT_REV_LIMIT = 0;
    localparam int DIO_BIT_FWD_LIMIT = 1;
    localparam int DIO_BIT_HOME = 2;
    localparam int DIO_GIN_LSB = 16;
    localparam int DIO_GIN_N = 7;
    localparam int DIO_BIT_SAFETY_1 = 24;
    localparam int DIO_BIT_SAFETY_2 = 25;

    // output and mask word field positions
    localparam int DIO_GOUT_LSB = 17;
    localparam int DIO_GOUT_N = 5;
    localparam logic [31:0] DIO_OUT_LEGAL = 32'h003E_0000;

    // reset values
    localparam logic [31:0] DIO_OUT_WORD_RST = 32'h0000_0000;
    localparam logic [31:0] DIO_MASK_RST = 32'h000C_0000;
    localparam logic [31:0] DIO_ENC_POS_RST = 32'h0000_0000;
    localparam logic [31:0] DIO_IN_WORD_RST = 32'h0000_0000;
    localparam logic [4:0] DIO_PINS_RST = 5'h00;

    typedef enum logic [1:0] {
        DIO_ABORT_NONE = 2'b00,
        DIO_ABORT_NO_OBJECT = 2'b01,
        DIO_ABORT_NO_SUB = 2'b10,
        DIO_ABORT_READ_ONLY = 2'b11
    } dio_abort_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } dio_req_type;

    typedef struct packed {
        logic done;
        dio_abort_type abort;
        logic [31:0] rdata;
    } dio_rsp_type;

    // keeps only the five output bit positions
    function automatic logic [31:0] dio_legal_out(input logic [31:0] word);
        return word & DIO_OUT_LEGAL;
    endfunction

    // extracts the five output bits
    function automatic logic [4:0] dio_out_field(input logic [31:0] word);
        return word[DIO_GOUT_LSB +: DIO_GOUT_N];
    endfunction

endpackage

`default_nettype wire

/* verilog/dio_in_word.sv */
/*
 * Registers the switch, general and safety inputs into the input state word.
 * Assumes all inputs are synchronous to ref_clk_i.
 */
`timescale 1ns/1ns
`default_nettype none

module dio_in_word (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic reverse_travel_limit_i,
    input wire logic forward_travel_limit_i,
    input wire logic home_switch_i,
    input wire logic [6:0] general_input_i,
    input wire logic safety_block_in_1_i,
    input wire logic safety_block_in_2_i,
    output logic [31:0] in_word_o
);
    import dio_pkg::*;

    logic [31:0] in_word_d;
    logic [31:0] in_word_q;

    always_comb begin
        in_word_d = 32'h0000_0000;
        in_word_d[DIO_BIT_REV_LIMIT] = reverse_travel_limit_i;
        in_word_d[DIO_BIT_FWD_LIMIT] = forward_travel_limit_i;
        in_word_d[DIO_BIT_HOME] = home_switch_i;
        in_word_d[DIO_GIN_LSB +: DIO_GIN_N] = general_input_i;
        in_word_d[DIO_BIT_SAFETY_1] = safety_block_in_1_i;
        in_word_d[DIO_BIT_SAFETY_2] = safety_block_in_2_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            in_word_q <= DIO_IN_WORD_RST;
        end else begin
            in_word_q <= in_word_d;
        end
    end

    assign in_word_o = in_word_q;

endmodule // dio_in_word

`default_nettype wire

/* verilog/dio_out_drive.sv */
/*
 * Drives the five general outputs from the masked output word ORed with status functions.
 * Assumes output word and mask come from registers of the parent.
 */
`timescale 1ns/1ns
`default_nettype none

module dio_out_drive (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] out_word_i,
    input wire logic [31:0] mask_i,
    input wire logic [4:0] status_func_i,
    input wire logic [4:0] status_assign_i,
    output logic [4:0] pins_o
);
    import dio_pkg::*;

    logic [4:0] pins_d;
    logic [4:0] pins_q;
    logic [4:0] masked;

    always_comb begin
        masked = dio_out_field(out_word_i) & dio_out_field(mask_i);
        // master-side duplicate avoidance relies on clearing the mask bit
        pins_d = masked | (status_func_i & status_assign_i);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pins_q <= DIO_PINS_RST;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign pins_o = pins_q;

endmodule // dio_out_drive

`default_nettype wire

/* verilog/dio_objects.sv */
/*
 * Digital I/O objects of the drive: input state word, output drive word with enable mask,
 * and external encoder position, all reached through one object access port.
 * Assumes the fieldbus side presents one request per cycle and the store keeps mask_store_o.
 */
// Notes on behaviour
// - input bits 0,1,2 show reverse limit, forward limit, home switch; 1 is ON
// - general inputs 0..6 appear in input bits 16..22; 1 is closed
// - safety block inputs 1 and 2 appear in input bits 24 and 25
// - output word bits 17..21 drive general outputs 1..5; 1 is ON
// - mask bits 17..21 enable the matching output word bit per pin
// - mask resets to 0x000C0000 and is stored; output word resets to zero, unstored
// - an assigned status function is ORed onto its pin with the masked setting
// - encoder position is read-only signed 32 bits, sub 1, default zero, count one
`timescale 1ns/1ns
`default_nettype none

module dio_objects (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire dio_pkg::dio_req_type obj_req_i,
    output dio_pkg::dio_rsp_type obj_rsp_o,
    input wire logic reverse_travel_limit_i,
    input wire logic forward_travel_limit_i,
    input wire logic home_switch_i,
    input wire logic [6:0] general_input_i,
    input wire logic safety_block_in_1_i,
    input wire logic safety_block_in_2_i,
    input wire logic [31:0] ext_encoder_pos_i,
    input wire logic ext_encoder_update_i,
    input wire logic [4:0] status_func_i,
    input wire logic [4:0] status_assign_i,
    input wire logic nv_restore_i,
    input wire logic [31:0] nv_mask_i,
    output logic [4:0] general_output_o,
    output logic [31:0] mask_store_o,
    output logic mask_save_o
);
    import dio_pkg::*;

    logic [31:0] in_word;
    logic [31:0] out_word_d;
    logic [31:0] out_word_q;
    logic [31:0] mask_d;
    logic [31:0] mask_q;
    logic mask_save_d;
    logic mask_save_q;
    logic signed [31:0] enc_pos_d;
    logic signed [31:0] enc_pos_q;
    dio_rsp_type rsp_d;
    dio_rsp_type rsp_q;
    logic req_any;

    dio_in_word u_in_word (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .reverse_travel_limit_i(reverse_travel_limit_i),
        .forward_travel_limit_i(forward_travel_limit_i),
        .home_switch_i(home_switch_i),
        .general_input_i(general_input_i),
        .safety_block_in_1_i(safety_block_in_1_i),
        .safety_block_in_2_i(safety_block_in_2_i),
        .in_word_o(in_word)
    );

    dio_out_drive u_out_drive (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .out_word_i(out_word_q),
        .mask_i(mask_q),
        .status_func_i(status_func_i),
        .status_assign_i(status_assign_i),
        .pins_o(general_output_o)
    );

    assign req_any = obj_req_i.rd | obj_req_i.wr;

    // encoder position sampled from the feedback path, never written by the master
    always_comb begin
        enc_pos_d = enc_pos_q;
        if (ext_encoder_update_i) begin
            enc_pos_d = ext_encoder_pos_i;
        end
    end

    // object access decode; a write wins over a read in the same request
    always_comb begin
        rsp_d = '{done: 1'b0, abort: DIO_ABORT_NONE, rdata: 32'h0000_0000};
        out_word_d = out_word_q;
        mask_d = mask_q;
        mask_save_d = 1'b0;
        // restore from the store first so a same-cycle master write overrides it
        if (nv_restore_i) begin
            mask_d = dio_legal_out(nv_mask_i);
        end
        if (req_any) begin
            rsp_d.done = 1'b1;
            unique case (obj_req_i.index)
                DIO_IDX_INPUTS: begin
                    if (obj_req_i.sub != DIO_SUB_COUNT) begin
                        rsp_d.abort = DIO_ABORT_NO_SUB;
                    end else if (obj_req_i.wr) begin
                        rsp_d.abort = DIO_ABORT_READ_ONLY;
                    end else begin
                        rsp_d.rdata = in_word;
                    end
                end
                DIO_IDX_OUTPUTS: begin
                    case (obj_req_i.sub)
                        DIO_SUB_COUNT: begin
                            if (obj_req_i.wr) begin
                                rsp_d.abort = DIO_ABORT_READ_ONLY;
                            end else begin
                                rsp_d.rdata = {24'h00_0000, DIO_OUT_COUNT};
                            end
                        end
                        DIO_SUB_OUT_WORD: begin
                            if (obj_req_i.wr) begin
                                out_word_d = dio_legal_out(obj_req_i.wdata);
                            end else begin
                                rsp_d.rdata = out_word_q;
                            end
                        end
                        DIO_SUB_MASK: begin
                            if (obj_req_i.wr) begin
                                mask_d = dio_legal_out(obj_req_i.wdata);
                                mask_save_d = 1'b1;
                            end else begin
                                rsp_d.rdata = mask_q;
                            end
                        end
                        default: begin
                            rsp_d.abort = DIO_ABORT_NO_SUB;
                        end
                    endcase
                end
                DIO_IDX_ENCODER: begin
                    case (obj_req_i.sub)
                        DIO_SUB_COUNT: begin
                            if (obj_req_i.wr) begin
                                rsp_d.abort = DIO_ABORT_READ_ONLY;
                            end else begin
                                rsp_d.rdata = {24'h00_0000, DIO_ENC_COUNT};
                            end
                        end
                        DIO_SUB_ENC_POS: begin
                            if (obj_req_i.wr) begin
                                rsp_d.abort = DIO_ABORT_READ_ONLY;
                            end else begin
                                rsp_d.rdata = enc_pos_q;
                            end
                        end
                        default: begin
                            rsp_d.abort = DIO_ABORT_NO_SUB;
                        end
                    endcase
                end
                default: begin
                    rsp_d.abort = DIO_ABORT_NO_OBJECT;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            out_word_q <= DIO_OUT_WORD_RST;
            mask_q <= DIO_MASK_RST;
            mask_save_q <= 1'b0;
            enc_pos_q <= DIO_ENC_POS_RST;
            rsp_q <= '{done: 1'b0, abort: DIO_ABORT_NONE, rdata: 32'h0000_0000};
        end else begin
            out_word_q <= out_word_d;
            mask_q <= mask_d;
            mask_save_q <= mask_save_d;
            enc_pos_q <= enc_pos_d;
            rsp_q <= rsp_d;
        end
    end

    // the store sees the live mask; mask_save_o marks when it changed by a write
    assign mask_store_o = mask_q;
    assign mask_save_o = mask_save_q;
    assign obj_rsp_o = rsp_q;

endmodule // dio_objects

`default_nettype wire

/* bench/dio_objects_asserts.sv */
/* Port checks for dio_objects: answers, input word, pins and mask store.
   Bound to dio_objects; one clock, synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module dio_objects_asserts (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire dio_pkg::dio_req_type obj_req_i,
    input wire dio_pkg::dio_rsp_type obj_rsp_o,
    input wire logic reverse_travel_limit_i,
    input wire logic forward_travel_limit_i,
    input wire logic home_switch_i,
    input wire logic [6:0] general_input_i,
    input wire logic safety_block_in_1_i,
    input wire logic safety_block_in_2_i,
    input wire logic [4:0] status_func_i,
    input wire logic [4:0] status_assign_i,
    input wire logic [4:0] general_output_o,
    input wire logic [31:0] mask_store_o,
    input wire logic mask_save_o
);
    import dio_pkg::*;
    dio_req_type q;
    dio_rsp_type p;
    logic take, rdi, mwr, owr;
    logic [31:0] in_exp, out_q, out_d;
    assign q = obj_req_i;
    assign p = obj_rsp_o;
    assign take = resetn_i && (q.rd || q.wr);
    assign rdi = take && !q.wr && q.index == DIO_IDX_INPUTS && q.sub == 8'h00;
    assign mwr = take && q.wr && q.index == DIO_IDX_OUTPUTS && q.sub == DIO_SUB_MASK;
    assign owr = take && q.wr && q.index == DIO_IDX_OUTPUTS && q.sub == DIO_SUB_OUT_WORD;
    assign in_exp = {6'h00, safety_block_in_2_i, safety_block_in_1_i, 1'b0, general_input_i, 13'h0000,
        home_switch_i, forward_travel_limit_i, reverse_travel_limit_i};
    // output word never reaches a port, so it is mirrored here
    always_comb begin
        out_d = !resetn_i ? 32'h0000_0000 : owr ? q.wdata & 32'h003E_0000 : out_q;
    end
    always_ff @(posedge ref_clk_i) begin
        out_q <= out_d;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    idle_zero_a: assert property (!take |=> p == '0) else $error("answer without request");
    in_word_a: assert property (rdi && $past(resetn_i) |=> p.done && p.rdata == $past(in_exp, 2))
        else $error("input word wrong");
    pin_drive_a: assert property ($past(resetn_i) |-> general_output_o ==
        $past(out_q[21:17] & mask_store_o[21:17] | status_func_i & status_assign_i)) else $error("pins wrong");
    mask_reset_a: assert property ($rose(resetn_i) |-> mask_store_o == 32'h000C_0000 && general_output_o == 5'h00)
        else $error("reset values wrong");
    mask_store_a: assert property (mwr |=> mask_save_o && mask_store_o == ($past(q.wdata) & 32'h003E_0000))
        else $error("mask store wrong");
    save_quiet_a: assert property (!mwr |=> !mask_save_o) else $error("stray save");
    ro_write_a: assert property (take && q.wr && q.index == DIO_IDX_ENCODER && q.sub <= 8'h01
        |=> p.abort == DIO_ABORT_READ_ONLY) else $error("encoder writable");
    out_rsvd_a: assert property (take && q.index == DIO_IDX_OUTPUTS && q.sub != 8'h00
        |=> (p.rdata & ~32'h003E_0000) == 32'h0000_0000) else $error("reserved bits set");
    cover property (mwr);
    cover property (rdi);
    cover property (p.abort == DIO_ABORT_NO_OBJECT);
endmodule // dio_objects_asserts
bind dio_objects dio_objects_asserts dio_objects_asserts_i (.ref_clk_i, .resetn_i, .obj_req_i, .obj_rsp_o,
    .reverse_travel_limit_i, .forward_travel_limit_i, .home_switch_i, .general_input_i, .safety_block_in_1_i,
    .safety_block_in_2_i, .status_func_i, .status_assign_i, .general_output_o, .mask_store_o, .mask_save_o);
`default_nettype wire

/* bench/dio_master_model.sv */
/* Fieldbus master model: one object request at a time, answer caught in its cycle.
   Called by the bench from a falling edge of ref_clk_i. */
`timescale 1ns/1ns
`default_nettype none
module dio_master_model (
    input wire logic ref_clk_i,
    input wire dio_pkg::dio_rsp_type obj_rsp_i,
    output dio_pkg::dio_req_type obj_req_o
);
    import dio_pkg::*;
    initial obj_req_o = '0;
    task automatic xfer(input logic w, input logic [15:0] x, input logic [7:0] s, input logic [31:0] d,
        output dio_rsp_type r);
        @(negedge ref_clk_i);
        obj_req_o = {~w, w, x, s, d};
        @(negedge ref_clk_i);
        // idle fields show the inverse, never the last value
        obj_req_o = {2'b00, ~x, ~s, ~d};
        r = obj_rsp_i;
    endtask
endmodule // dio_master_model
`default_nettype wire

/* bench/dio_objects_tb_top.sv */
/* Bench for dio_objects: pins driven here, objects reached through the master model.
   Needs the package, the design, the model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module dio_objects_tb_top;
    import dio_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic rl, fl, hs, s1, s2, upd, nvr;
    logic [6:0] gin;
    logic [4:0] sf, sa, pins;
    logic [31:0] pos, nvm;
    logic [11:0] pat [3] = '{12'hAAA, 12'h555, 12'hFFF};
    dio_req_type req;
    dio_rsp_type rsp, r;
    int failures = 0;
    int total_checks = 0;
    always #50 ref_clk = ~ref_clk;
    dio_master_model dio_master_model_i (.ref_clk_i(ref_clk), .obj_rsp_i(rsp), .obj_req_o(req));
    dio_objects dio_objects_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .obj_req_i(req), .obj_rsp_o(rsp),
        .reverse_travel_limit_i(rl), .forward_travel_limit_i(fl), .home_switch_i(hs), .general_input_i(gin),
        .safety_block_in_1_i(s1), .safety_block_in_2_i(s2), .ext_encoder_pos_i(pos), .ext_encoder_update_i(upd),
        .status_func_i(sf), .status_assign_i(sa), .nv_restore_i(nvr), .nv_mask_i(nvm), .general_output_o(pins),
        .mask_store_o(), .mask_save_o());
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // data is compared only on a clean read
    task automatic acc(input logic w, input logic [15:0] x, input logic [7:0] s, input logic [31:0] d,
        input dio_abort_type ea, input logic [31:0] ed);
        dio_master_model_i.xfer(w, x, s, d, r);
        // a missing answer ends the run through the closing report
        chk("done", 32'h0000_0001, 32'(r.done));
        if (r.done !== 1'b1) begin
            summarize();
        end
        chk("abort", 32'(ea), 32'(r.abort));
        if (!w && ea == DIO_ABORT_NONE) begin
            chk("rdata", ed, r.rdata);
        end
    endtask
    task automatic pchk(input logic [4:0] e);
        @(negedge ref_clk);
        chk("pins", 32'(e), 32'(pins));
    endtask
    initial begin
        {rl, fl, hs, s1, s2, upd, nvr, gin, sf, sa} = '0;
        pos = 32'h8000_0001;
        nvm = 32'hFFFF_FFFF;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        acc(0, 16'h60FE, 8'h02, '0, DIO_ABORT_NONE, 32'h000C_0000);
        acc(0, 16'h60FE, 8'h01, '0, DIO_ABORT_NONE, 32'h0000_0000);
        acc(0, 16'h60FE, 8'h00, '0, DIO_ABORT_NONE, 32'h0000_0002);
        acc(0, 16'h60E4, 8'h00, '0, DIO_ABORT_NONE, 32'h0000_0001);
        foreach (pat[i]) begin
            {s2, s1, gin, hs, fl, rl} = pat[i];
            acc(0, 16'h60FD, 8'h00, '0, DIO_ABORT_NONE,
                {6'h00, pat[i][11:10], 1'b0, pat[i][9:3], 13'h0000, pat[i][2:0]});
        end
        acc(1, 16'h60FE, 8'h02, 32'hFFFF_FFFF, DIO_ABORT_NONE, '0);
        acc(0, 16'h60FE, 8'h02, '0, DIO_ABORT_NONE, 32'h003E_0000);
        acc(1, 16'h60FE, 8'h01, 32'hFFFF_FFFF, DIO_ABORT_NONE, '0);
        acc(0, 16'h60FE, 8'h01, '0, DIO_ABORT_NONE, 32'h003E_0000);
        pchk(5'h1F);
        for (int k = 0; k < 5; k++) begin
            acc(1, 16'h60FE, 8'h02, 32'h0002_0000 << k, DIO_ABORT_NONE, '0);
            pchk(5'h01 << k);
        end
        // output 1 carries a status function, so its mask bit is cleared
        acc(1, 16'h60FE, 8'h02, 32'h003C_0000, DIO_ABORT_NONE, '0);
        sf = 5'h1F;
        sa = 5'h01;
        pchk(5'h1F);
        sa = 5'h00;
        pchk(5'h1E);
        sa = 5'h03;
        acc(1, 16'h60FE, 8'h01, 32'h0000_0000, DIO_ABORT_NONE, '0);
        pchk(5'h03);
        // assignment alone must not light a pin whose status level is low
        sf = 5'h02;
        pchk(5'h02);
        acc(1, 16'h60FD, 8'h00, 32'hFFFF_FFFF, DIO_ABORT_READ_ONLY, '0);
        acc(1, 16'h60E4, 8'h01, 32'h1234_5678, DIO_ABORT_READ_ONLY, '0);
        acc(1, 16'h60FE, 8'h00, 32'h0000_0007, DIO_ABORT_READ_ONLY, '0);
        acc(0, 16'h60FE, 8'h03, '0, DIO_ABORT_NO_SUB, '0);
        acc(0, 16'h6000, 8'h00, '0, DIO_ABORT_NO_OBJECT, '0);
        acc(0, 16'h60E4, 8'h01, '0, DIO_ABORT_NONE, 32'h0000_0000);
        upd = 1'b1;
        @(negedge ref_clk);
        upd = 1'b0;
        acc(0, 16'h60E4, 8'h01, '0, DIO_ABORT_NONE, 32'h8000_0001);
        nvr = 1'b1;
        @(negedge ref_clk);
        nvr = 1'b0;
        acc(0, 16'h60FE, 8'h02, '0, DIO_ABORT_NONE, 32'h003E_0000);
        summarize();
    end
endmodule // dio_objects_tb_top
`default_nettype wire
